// ### intcpd_decoder.sv
// register page decoder: axi4 slave front end with page select and size checking
`default_nettype none
// Summary of operation
// [R1] single clock and single active-low reset
// [R2] all inputs synchronous to clock, external sync
// [R3] reserved space: okay, reads zero, writes dropped
// [R4] reset clears all held state to zero
// [R5] software preserves and ignores reserved bits
// [R6] slave data path is 32 bits
// [R7] byte-capable registers also accept halfwords
// [R8] word-capable registers also accept doublewords
// [R9] unsupported narrow access gives slverr, no update
// [R10] doubleword split into two atomic word beats
// [R11] little-endian byte lanes only
// [R12] write-only reads have no side effect
// [R13] each page is a 64kb region
// [R14] address width is 18 plus core bits
// [R15] top address bit picks redistributor half
// [R16] lower page index 0..3 decoded, others reserved
// [R17] upper bits above 16 give core number
// [R18] bit 16 picks control or private page
// [R19] unimplemented core numbers are reserved
// [R20] redistributor pages in cluster order
// [R21] software avoids unreachable multi-core interrupts
// [R22] unreachable shared interrupt raises no wakeup
// [R23] reserved pages read zero, okay response
module intcpd_decoder (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [intcpd_pkg::ID_W-1:0] awid_i,
  input wire logic [intcpd_pkg::ADDR_W-1:0] awaddr_i,
  input wire logic [7:0] awlen_i,
  input wire logic [2:0] awsize_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [intcpd_pkg::DATA_W-1:0] wdata_i,
  input wire logic [intcpd_pkg::STRB_W-1:0] wstrb_i,
  input wire logic wlast_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [intcpd_pkg::ID_W-1:0] bid_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [intcpd_pkg::ID_W-1:0] arid_i,
  input wire logic [intcpd_pkg::ADDR_W-1:0] araddr_i,
  input wire logic [7:0] arlen_i,
  input wire logic [2:0] arsize_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [intcpd_pkg::ID_W-1:0] rid_o,
  output logic [intcpd_pkg::DATA_W-1:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rlast_o,
  output logic rvalid_o,
  input wire logic rready_i,
  input wire logic [intcpd_pkg::NUM_CORES-1:0] wake_cand_i,
  input wire logic [intcpd_pkg::NUM_CORES-1:0] core_accept_i,
  input wire logic single_target_i,
  output logic [intcpd_pkg::NUM_CORES-1:0] wake_request_o,
  output logic [intcpd_pkg::ADDR_W-1:0] page_addr_o,
  output logic [2:0] page_sel_o,
  output logic [intcpd_pkg::CORE_BITS-1:0] page_core_o,
  output logic page_we_o,
  output logic [intcpd_pkg::DATA_W-1:0] page_wdata_o,
  output logic [intcpd_pkg::STRB_W-1:0] page_wstrb_o,
  output logic page_re_o,
  input wire logic [intcpd_pkg::DATA_W-1:0] page_rdata_i,
  input wire logic page_word_only_i
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WDATA,
    ST_WRESP
  } intcpd_wstate_t;

  typedef enum logic [1:0] {
    RS_IDLE,
    RS_LOOK,
    RS_DATA
  } intcpd_rstate_t;

  // decode of one address into a page, with a core-number range check; one function keeps both channels identical [R13] [R14]
  function automatic intcpd_pkg::intcpd_page_t decode_page(input logic [intcpd_pkg::ADDR_W-1:0] a);
    logic [intcpd_pkg::ADDR_W-2-intcpd_pkg::PAGE_LSB:0] idx;
    logic [intcpd_pkg::CORE_BITS-1:0] core;
    idx = a[intcpd_pkg::ADDR_W-2:intcpd_pkg::PAGE_LSB];
    core = a[intcpd_pkg::ADDR_W-2:intcpd_pkg::PAGE_LSB+1];
    decode_page = intcpd_pkg::PG_NONE;
    if (!a[intcpd_pkg::ADDR_W-1]) begin // [R15]
      if (idx == {{(intcpd_pkg::ADDR_W-3-intcpd_pkg::PAGE_LSB){1'b0}}, intcpd_pkg::LOW_DIST}) begin // [R16]
        decode_page = intcpd_pkg::PG_DIST;
      end else if (idx == {{(intcpd_pkg::ADDR_W-3-intcpd_pkg::PAGE_LSB){1'b0}}, intcpd_pkg::LOW_MSG}) begin
        decode_page = intcpd_pkg::PG_MSG;
      end else if (idx == {{(intcpd_pkg::ADDR_W-3-intcpd_pkg::PAGE_LSB){1'b0}}, intcpd_pkg::LOW_TSCTL}) begin
        decode_page = intcpd_pkg::PG_TSCTL;
      end else if (idx == {{(intcpd_pkg::ADDR_W-3-intcpd_pkg::PAGE_LSB){1'b0}}, intcpd_pkg::LOW_TWRITE}) begin
        decode_page = intcpd_pkg::PG_TWRITE;
      end
    end else if (32'(core) < intcpd_pkg::NUM_CORES) begin // [R17] [R19] [R20]
      decode_page = a[intcpd_pkg::PAGE_LSB] ? intcpd_pkg::PG_RD_PRIV : intcpd_pkg::PG_RD_CTL; // [R18]
    end
  endfunction : decode_page

  // narrow sizes fail on word-only registers; dword/word always fine [R7] [R8] [R9]
  function automatic logic size_bad(input logic [2:0] sz, input logic word_only);
    size_bad = word_only && (sz == intcpd_pkg::SIZE_BYTE || sz == intcpd_pkg::SIZE_HALF);
  endfunction : size_bad

  intcpd_wstate_t wst_reg;
  intcpd_rstate_t rst_reg;
  logic [intcpd_pkg::ADDR_W-1:0] waddr_reg;
  logic [2:0] wsize_reg;
  logic [intcpd_pkg::ID_W-1:0] wid_reg;
  logic werr_reg;
  logic [intcpd_pkg::ADDR_W-1:0] raddr_reg;
  logic [2:0] rsize_reg;
  logic [7:0] rcnt_reg;
  logic [intcpd_pkg::ID_W-1:0] rid_reg;
  logic [intcpd_pkg::DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [intcpd_pkg::NUM_CORES-1:0] wake_reg;
  intcpd_pkg::intcpd_page_t wpage;
  intcpd_pkg::intcpd_page_t rpage;
  logic wbeat;
  logic w_ok;

  assign wpage = decode_page(waddr_reg);
  assign rpage = decode_page(raddr_reg);
  assign wbeat = (wst_reg == ST_WDATA) && wvalid_i;
  assign w_ok = (wpage != intcpd_pkg::PG_NONE) && !size_bad(wsize_reg, page_word_only_i);

  assign awready_o = (wst_reg == ST_IDLE);
  assign wready_o = (wst_reg == ST_WDATA);
  assign bvalid_o = (wst_reg == ST_WRESP);
  assign bid_o = wid_reg;
  assign bresp_o = werr_reg ? intcpd_pkg::RESP_SLVERR : intcpd_pkg::RESP_OKAY;
  assign arready_o = (rst_reg == RS_IDLE);
  assign rvalid_o = (rst_reg == RS_DATA);
  assign rid_o = rid_reg;
  assign rdata_o = rdata_reg;
  assign rresp_o = rresp_reg;
  assign rlast_o = (rcnt_reg == 8'h00);

  // page strobes: write strobe only on a legal, mapped beat, never on reserved space [R3] [R9] [R23]
  assign page_we_o = wbeat && w_ok;
  assign page_re_o = (rst_reg == RS_LOOK) && (rpage != intcpd_pkg::PG_NONE); // [R12]
  assign page_addr_o = (rst_reg == RS_LOOK) ? raddr_reg : waddr_reg;
  assign page_sel_o = 3'((rst_reg == RS_LOOK) ? rpage : wpage);
  assign page_core_o = (rst_reg == RS_LOOK) ? raddr_reg[intcpd_pkg::ADDR_W-2:intcpd_pkg::PAGE_LSB+1]
                                            : waddr_reg[intcpd_pkg::ADDR_W-2:intcpd_pkg::PAGE_LSB+1];
  assign page_wdata_o = wdata_i; // [R6] [R11] lanes pass straight, little-endian
  assign page_wstrb_o = wstrb_i;

  // write channel; each 32-bit beat is one atomic page write [R10]
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin // [R1] [R2]
    if (!nrst_i) begin // [R4]
      wst_reg <= ST_IDLE;
      waddr_reg <= '0;
      wsize_reg <= '0;
      wid_reg <= '0;
      werr_reg <= 1'b0;
    end else begin
      case (wst_reg)
        ST_IDLE: begin
          if (awvalid_i) begin
            waddr_reg <= awaddr_i;
            wsize_reg <= awsize_i;
            wid_reg <= awid_i;
            werr_reg <= 1'b0;
            wst_reg <= ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (wvalid_i) begin
            if (size_bad(wsize_reg, page_word_only_i) && wpage != intcpd_pkg::PG_NONE) begin
              werr_reg <= 1'b1; // [R9]
            end
            waddr_reg <= waddr_reg + intcpd_pkg::ADDR_W'(intcpd_pkg::STRB_W);
            if (wlast_i) begin
              wst_reg <= ST_WRESP;
            end
          end
        end
        ST_WRESP: begin
          if (bready_i) begin
            wst_reg <= ST_IDLE;
          end
        end
        default: wst_reg <= ST_IDLE;
      endcase
    end
  end

  // read channel: capture, one lookup cycle, then data; reserved reads zero [R3] [R23]
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_reg <= RS_IDLE;
      raddr_reg <= '0;
      rsize_reg <= '0;
      rcnt_reg <= '0;
      rid_reg <= '0;
      rdata_reg <= intcpd_pkg::DATA_ZERO;
      rresp_reg <= intcpd_pkg::RESP_OKAY;
    end else begin
      case (rst_reg)
        RS_IDLE: begin
          if (arvalid_i) begin
            raddr_reg <= araddr_i;
            rsize_reg <= arsize_i;
            rcnt_reg <= arlen_i;
            rid_reg <= arid_i;
            rst_reg <= RS_LOOK;
          end
        end
        RS_LOOK: begin
          if (rpage == intcpd_pkg::PG_NONE) begin
            rdata_reg <= intcpd_pkg::DATA_ZERO;
            rresp_reg <= intcpd_pkg::RESP_OKAY;
          end else if (size_bad(rsize_reg, page_word_only_i)) begin
            rdata_reg <= intcpd_pkg::DATA_ZERO;
            rresp_reg <= intcpd_pkg::RESP_SLVERR;
          end else begin
            rdata_reg <= page_rdata_i;
            rresp_reg <= intcpd_pkg::RESP_OKAY;
          end
          rst_reg <= RS_DATA;
        end
        RS_DATA: begin
          if (rready_i) begin
            if (rcnt_reg == 8'h00) begin
              rst_reg <= RS_IDLE;
            end else begin
              rcnt_reg <= rcnt_reg - 8'h01;
              raddr_reg <= raddr_reg + intcpd_pkg::ADDR_W'(intcpd_pkg::STRB_W);
              rst_reg <= RS_LOOK;
            end
          end
        end
        default: rst_reg <= RS_IDLE;
      endcase
    end
  end

  // wakeup only for interrupts aimed at a single core; a multi-target one nobody takes stays quiet [R22]
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wake_reg <= '0;
    end else begin
      wake_reg <= single_target_i ? (wake_cand_i & ~core_accept_i) : '0;
    end
  end
  assign wake_request_o = wake_reg;

  sequence s_res_read;
    rst_reg == RS_LOOK && rpage == intcpd_pkg::PG_NONE;
  endsequence

  sequence s_zero_okay;
    rvalid_o && rdata_o == intcpd_pkg::DATA_ZERO && rresp_o == intcpd_pkg::RESP_OKAY;
  endsequence

  a_reserved_read_zero: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R3]
    s_res_read |=> s_zero_okay) else $error("reserved read not zero okay");

  a_reserved_no_write: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R23]
    (wpage == intcpd_pkg::PG_NONE) |-> !page_we_o) else $error("write reached reserved page");

  a_narrow_no_update: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R9]
    (wbeat && page_word_only_i && wsize_reg == intcpd_pkg::SIZE_BYTE) |-> !page_we_o)
    else $error("narrow write updated register");

  a_narrow_slverr: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R9]
    (wbeat && wlast_i && page_word_only_i && wsize_reg == intcpd_pkg::SIZE_HALF && wpage != intcpd_pkg::PG_NONE)
    |=> bvalid_o && bresp_o == intcpd_pkg::RESP_SLVERR) else $error("narrow write missing slverr");

  a_dword_accept: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R8]
    (wbeat && wsize_reg == intcpd_pkg::SIZE_DWORD && wpage != intcpd_pkg::PG_NONE) |-> page_we_o)
    else $error("doubleword write refused");

  a_half_accept: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R7]
    (wbeat && !page_word_only_i && wsize_reg == intcpd_pkg::SIZE_HALF && wpage != intcpd_pkg::PG_NONE)
    |-> page_we_o) else $error("halfword write refused");

  a_top_bit_half: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R15]
    (page_re_o && raddr_reg[intcpd_pkg::ADDR_W-1])
    |-> (rpage == intcpd_pkg::PG_RD_CTL || rpage == intcpd_pkg::PG_RD_PRIV))
    else $error("upper half decoded as lower page");

  a_bit16_select: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R18]
    (page_re_o && raddr_reg[intcpd_pkg::ADDR_W-1])
    |-> (raddr_reg[intcpd_pkg::PAGE_LSB] == (rpage == intcpd_pkg::PG_RD_PRIV)))
    else $error("bit 16 page select wrong");

  a_no_wake_multi: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R22]
    !single_target_i |=> wake_request_o == '0) else $error("wakeup for multi-target interrupt");

  a_read_no_update: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R12]
    (rst_reg == RS_LOOK) |-> !page_we_o) else $error("read caused a write strobe");

  // narrow read on a word-only register answers zero with an error, never the register value
  sequence s_narrow_read;
    rst_reg == RS_LOOK && rpage != intcpd_pkg::PG_NONE && size_bad(rsize_reg, page_word_only_i);
  endsequence

  sequence s_zero_slverr;
    rvalid_o && rdata_o == intcpd_pkg::DATA_ZERO && rresp_o == intcpd_pkg::RESP_SLVERR;
  endsequence

  sequence s_good_read;
    rst_reg == RS_LOOK && rpage != intcpd_pkg::PG_NONE && !size_bad(rsize_reg, page_word_only_i);
  endsequence

  sequence s_res_last;
    wbeat && wlast_i && wpage == intcpd_pkg::PG_NONE && !werr_reg;
  endsequence

  a_narrow_read_err: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R9]
    s_narrow_read |=> s_zero_slverr) else $error("narrow read not refused");

  a_read_data_pass: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R11]
    s_good_read |=> rvalid_o && rdata_o == $past(page_rdata_i) && rresp_o == intcpd_pkg::RESP_OKAY)
    else $error("mapped read data lost");

  a_reserved_write_okay: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R3]
    s_res_last |=> bvalid_o && bresp_o == intcpd_pkg::RESP_OKAY) else $error("reserved write not okay");

  a_lower_index: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R16]
    (page_re_o && !raddr_reg[intcpd_pkg::ADDR_W-1])
    |-> (rpage inside {intcpd_pkg::PG_DIST, intcpd_pkg::PG_MSG, intcpd_pkg::PG_TSCTL, intcpd_pkg::PG_TWRITE}))
    else $error("lower page index misdecoded");

  a_core_reserved: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R19]
    (raddr_reg[intcpd_pkg::ADDR_W-1]
    && 32'(raddr_reg[intcpd_pkg::ADDR_W-2:intcpd_pkg::PAGE_LSB+1]) >= intcpd_pkg::NUM_CORES)
    |-> rpage == intcpd_pkg::PG_NONE) else $error("unimplemented core decoded");

  a_wake_single: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R22]
    single_target_i |=> (wake_request_o == ($past(wake_cand_i) & ~$past(core_accept_i))))
    else $error("single-target wakeup wrong");

  a_last_beat_resp: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [R10]
    (wbeat && wlast_i) |=> bvalid_o) else $error("write response missing");

endmodule : intcpd_decoder
`default_nettype wire

// ### intcpd_pkg.sv
// constants for the interrupt controller register page decoder
`default_nettype none
package intcpd_pkg;
  localparam int unsigned NUM_CORES = 4;
  localparam int unsigned CORE_BITS = (NUM_CORES <= 2) ? 1 : $clog2(NUM_CORES);
  localparam int unsigned PAGE_LSB = 16;
  localparam int unsigned ADDR_W = 18 + CORE_BITS;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = DATA_W / 8;
  localparam int unsigned ID_W = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] SIZE_BYTE = 3'h0;
  localparam logic [2:0] SIZE_HALF = 3'h1;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic [2:0] SIZE_DWORD = 3'h3;
  localparam logic [1:0] LOW_DIST = 2'h0;
  localparam logic [1:0] LOW_MSG = 2'h1;
  localparam logic [1:0] LOW_TSCTL = 2'h2;
  localparam logic [1:0] LOW_TWRITE = 2'h3;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
  typedef enum logic [2:0] {
    PG_NONE,
    PG_DIST,
    PG_MSG,
    PG_TSCTL,
    PG_TWRITE,
    PG_RD_CTL,
    PG_RD_PRIV
  } intcpd_page_t;
endpackage : intcpd_pkg
`default_nettype wire

// ### intcpd_bank_model.sv
// behavioural register bank that answers the decoder's page read strobe
`default_nettype none
module intcpd_bank_model (
  input wire logic [intcpd_pkg::ADDR_W-1:0] page_addr_i,
  input wire logic page_re_i,
  output logic [intcpd_pkg::DATA_W-1:0] page_rdata_o
);
  // data depends on the address so a misrouted lookup shows; idle value is the inverse
  assign page_rdata_o = page_re_i ? {12'ha5a, page_addr_i} : ~{12'ha5a, page_addr_i};
endmodule : intcpd_bank_model
`default_nettype wire

// ### test_intcpd_decoder.sv
// self-checking bench for the register page decoder
`default_nettype none
module test_intcpd_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] awid_i = 4'h0, arid_i = 4'h0, wstrb_i = 4'h0;
  logic [19:0] awaddr_i = 20'h0, araddr_i = 20'h0, page_addr_o;
  logic [7:0] awlen_i = 8'h0, arlen_i = 8'h0;
  logic [2:0] awsize_i = 3'h2, arsize_i = 3'h2, page_sel_o;
  logic awvalid_i = 1'b0, wlast_i = 1'b0, wvalid_i = 1'b0, arvalid_i = 1'b0, single_target_i = 1'b0;
  logic word_only = 1'b0, awready_o, wready_o, bvalid_o, arready_o, rlast_o, rvalid_o, page_we_o, page_re_o;
  logic [31:0] wdata_i = 32'h0, rdata_o, page_wdata_o, page_rdata_i;
  logic [3:0] wake_cand_i = 4'h0, core_accept_i = 4'h0, bid_o, rid_o, wake_request_o, page_wstrb_o;
  logic [1:0] bresp_o, rresp_o, page_core_o;
  int num_errors = 0;
  int n_checks = 0;
  logic [2:0] sel;
  logic [1:0] core, resp;
  logic [31:0] data;
  logic hit;
  always #10 ref_clk_i = ~ref_clk_i;
  intcpd_decoder dut_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .awid_i(awid_i), .awaddr_i(awaddr_i),
    .awlen_i(awlen_i), .awsize_i(awsize_i), .awvalid_i(awvalid_i), .awready_o(awready_o), .wdata_i(wdata_i),
    .wstrb_i(wstrb_i), .wlast_i(wlast_i), .wvalid_i(wvalid_i), .wready_o(wready_o), .bid_o(bid_o),
    .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(1'b1), .arid_i(arid_i), .araddr_i(araddr_i),
    .arlen_i(arlen_i), .arsize_i(arsize_i), .arvalid_i(arvalid_i), .arready_o(arready_o), .rid_o(rid_o),
    .rdata_o(rdata_o), .rresp_o(rresp_o), .rlast_o(rlast_o), .rvalid_o(rvalid_o), .rready_i(1'b1),
    .wake_cand_i(wake_cand_i), .core_accept_i(core_accept_i), .single_target_i(single_target_i),
    .wake_request_o(wake_request_o), .page_addr_o(page_addr_o), .page_sel_o(page_sel_o),
    .page_core_o(page_core_o), .page_we_o(page_we_o), .page_wdata_o(page_wdata_o), .page_wstrb_o(page_wstrb_o),
    .page_re_o(page_re_o), .page_rdata_i(page_rdata_i), .page_word_only_i(word_only));
  intcpd_bank_model bank_u (.page_addr_i(page_addr_o), .page_re_i(page_re_o), .page_rdata_o(page_rdata_i));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one read beat; the lookup cycle's select and core are captured while page_re_o is high
  task automatic rd(input logic [19:0] a, input logic [2:0] sz);
    hit = 1'b0;
    araddr_i <= a;
    arsize_i <= sz;
    arvalid_i <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge ref_clk_i);
      if (arvalid_i && arready_o) arvalid_i <= 1'b0;
      if (page_re_o) begin
        hit = 1'b1;
        sel = page_sel_o;
        core = page_core_o;
      end
      if (rvalid_o) begin
        data = rdata_o;
        resp = rresp_o;
        return;
      end
    end
    check(32'h1, 32'h0);
  endtask : rd
  // one write beat, address and data offered together; hit records a page write strobe
  task automatic wr(input logic [19:0] a, input logic [2:0] sz, input logic [3:0] st);
    hit = 1'b0;
    awaddr_i <= a;
    awsize_i <= sz;
    awvalid_i <= 1'b1;
    wdata_i <= {12'h3c3, a}; // whole words, driven on the edge
    wstrb_i <= st;
    wlast_i <= 1'b1;
    wvalid_i <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge ref_clk_i);
      if (awvalid_i && awready_o) awvalid_i <= 1'b0;
      if (wvalid_i && wready_o) begin
        wvalid_i <= 1'b0;
        hit = hit | page_we_o;
      end
      if (bvalid_o) begin
        resp = bresp_o;
        return;
      end
    end
    check(32'h1, 32'h0);
  endtask : wr
  task automatic t_pages();
    logic [19:0] addrs [6] = '{20'h00010, 20'h10020, 20'h20030, 20'h30040, 20'hc0050, 20'hf0060};
    logic [1:0] cores [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h3};
    for (int k = 0; k < 6; k++) begin
      rd(addrs[k], intcpd_pkg::SIZE_WORD);
      check(32'(sel), 32'(k + 1));
      if (k > 3) check(32'(core), 32'(cores[k]));
      check(data, {12'ha5a, addrs[k]});
      check(32'(resp), 32'(intcpd_pkg::RESP_OKAY));
    end
    $display("test pages done");
  endtask : t_pages
  task automatic t_reserved();
    rd(20'h40008, intcpd_pkg::SIZE_WORD);
    check(32'(hit), 32'h0);
    check(data, intcpd_pkg::DATA_ZERO);
    check(32'(resp), 32'(intcpd_pkg::RESP_OKAY));
    wr(20'h70000, intcpd_pkg::SIZE_WORD, 4'hf);
    check(32'(hit), 32'h0);
    check(32'(resp), 32'(intcpd_pkg::RESP_OKAY));
    $display("test reserved done");
  endtask : t_reserved
  task automatic t_sizes();
    word_only <= 1'b1;
    wr(20'h00020, intcpd_pkg::SIZE_BYTE, 4'h1);
    check(32'(hit), 32'h0);
    check(32'(resp), 32'(intcpd_pkg::RESP_SLVERR));
    wr(20'h00028, intcpd_pkg::SIZE_HALF, 4'h3);
    check(32'(hit), 32'h0);
    check(32'(resp), 32'(intcpd_pkg::RESP_SLVERR));
    rd(20'h00022, intcpd_pkg::SIZE_HALF);
    check(32'(resp), 32'(intcpd_pkg::RESP_SLVERR));
    rd(20'h00024, intcpd_pkg::SIZE_DWORD);
    check(32'(resp), 32'(intcpd_pkg::RESP_OKAY));
    word_only <= 1'b0;
    wr(20'h00026, intcpd_pkg::SIZE_HALF, 4'hc);
    check(32'(hit), 32'h1);
    check(32'(resp), 32'(intcpd_pkg::RESP_OKAY));
    $display("test sizes done");
  endtask : t_sizes
  task automatic t_wake();
    single_target_i <= 1'b1;
    wake_cand_i <= 4'hf;
    core_accept_i <= 4'h5;
    repeat (2) @(posedge ref_clk_i);
    check(32'(wake_request_o), 32'h0000000a);
    single_target_i <= 1'b0;
    core_accept_i <= 4'h0;
    repeat (2) @(posedge ref_clk_i);
    check(32'(wake_request_o), 32'h0);
    $display("test wake done");
  endtask : t_wake
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  initial begin
    // a stalled handshake never stops the run on its own
    #200000;
    num_errors++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    check(32'({bvalid_o, rvalid_o, wake_request_o}), 32'h0);
    t_pages();
    t_reserved();
    t_sizes();
    t_wake();
    close_out();
  end
endmodule : test_intcpd_decoder
`default_nettype wire
